// File: bench/encoder_model.sv
// Incremental encoder model driving the two counting lines.
module encoder_model #(parameter int STEP = 100) (
    input  wire logic core_clk, // Clock
    input  wire logic run,      // Rotate while high
    input  wire logic dir,      // High turns backwards
    input  wire logic pulse,    // Single pulse wiring
    output wire logic a,        // Phase A line
    output wire logic b         // Phase B or pulse line
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;
    logic [1:0] ph  = 2'h0;
    // One phase step per STEP cycles holds each line to 100 kHz.
    always @(posedge core_clk) if (run) begin
        cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
        if (cnt == STEP - 1) ph <= dir ? ph - 2'h1 : ph + 2'h1;
    end
    assign a = pulse ? 1'b0 : ph[1];
    assign b = pulse ? ph[1] : ph[1] ^ ph[0];
endmodule

// File: bench/encoder_properties.sv
// Port checker for decoding, clearing and input inversion.
module encoder_properties #(parameter int NUM_INPUTS = 7) (
    input wire                  core_clk,  // Clock
    input wire                  reset_n,   // Reset, active low
    input wire [NUM_INPUTS-1:0] din_raw,   // Terminal levels
    input wire [NUM_INPUTS-1:0] din_value, // Levels after inversion
    input wire [15:0]           position,  // Signed count
    input wire                  psel,      // APB select
    input wire                  penable,   // APB enable
    input wire                  pwrite,    // APB write
    input wire [11:0]           paddr,     // APB address
    input wire [31:0]           pwdata,    // APB write data
    input wire [31:0]           prdata     // APB read data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [14:0] ctl;
    wire         wr  = psel && penable && pwrite;
    wire         run = !ctl[2] && !wr;
    // A shadow of the control word, so the checks need no internal signal.
    always @(posedge core_clk)
        if (!reset_n) ctl <= 15'h0000;
        else if (wr && paddr == 12'h000) ctl <= pwdata[14:0];
    property p_din_pass; 1 |=> din_value == ($past(din_raw) ^ $past(ctl[14:8]));
    endproperty
    a_din_pass: assert property (p_din_pass) else $error("input level");
    property p_clear; ctl[2] && $past(ctl[2]) |-> position == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not held");
    property p_quad_step; ctl[1:0] == 2'h0 && run
        && $onehot(din_value[6:5] ^ $past(din_value[6:5])) |=> position ==
        $past(position) + (($past(din_value[5], 2) ^ $past(din_value[6])
        ^ $past(ctl[3])) ? 16'h0001 : 16'hFFFF); endproperty
    a_quad_step: assert property (p_quad_step) else $error("quad step");
    property p_quad_double; ctl[1:0] == 2'h0 && run
        && (din_value[6:5] ^ $past(din_value[6:5])) == 2'h3 |=> $stable(position);
    endproperty
    a_quad_double: assert property (p_quad_double) else $error("double");
    property p_pulse; ctl[1:0] == 2'h2 && run && $rose(din_value[6]) |=>
        position == $past(position) + ($past(ctl[3]) ? 16'hFFFF : 16'h0001);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse count");
    property p_pulse_idle; ctl[1:0] == 2'h2 && run && !$rose(din_value[6])
        |=> $stable(position); endproperty
    a_pulse_idle: assert property (p_pulse_idle) else $error("idle");
    property p_step; run |=> (position - $past(position)) inside
        {16'h0000, 16'h0001, 16'hFFFF}; endproperty
    a_step: assert property (p_step) else $error("position jump");
    property p_read_pos; psel && penable && !pwrite && paddr == 12'h010
        |-> prdata == {{16{position[15]}}, position}; endproperty
    a_read_pos: assert property (p_read_pos) else $error("position read");
endmodule
bind encoder_speed_position_input encoder_properties
    #(.NUM_INPUTS(NUM_INPUTS)) encoder_properties_i (.*);

// File: bench/test_encoder_speed_position_input.sv
// Bench: APB reads compared with queued expectations.
module test_encoder_speed_position_input;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic run = 0, dir = 0, pulse = 0, a, b;
    logic [4:0] raw = 5'h00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, q[$];
    wire [6:0] din_value;
    wire [15:0] position;
    wire [31:0] prdata, hz, rpm, pct;
    wire pready, pslverr;
    int err_count = 0, checks_done = 0;
    always #12.5 core_clk = ~core_clk;
    encoder_model encoder_model_i (.core_clk(core_clk), .run(run),
        .dir(dir), .pulse(pulse), .a(a), .b(b));
    encoder_speed_position_input #(.GATE_CYCLES(200))
        encoder_speed_position_input_i (.core_clk(core_clk),
        .reset_n(reset_n), .din_raw({b, a, raw}), .din_value(din_value),
        .position(position), .speed_hertz(hz), .speed_rev_per_min(rpm),
        .speed_percent(pct), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_err(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t error flag %b, expected %b", $time, got, exp);
        end
    endtask
    always @(posedge core_clk)
        if (psel && penable && pready && !pwrite) chk(prdata, q.pop_front());
    always @(posedge core_clk)
        if (psel && penable && pready) chk_err(pslverr, paddr > 12'h01C);
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d, input logic [31:0] e);
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
        if (!w) q.push_back(e);
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        {psel, penable} <= 2'b00;
    endtask
    task automatic spin(input int n, input logic d);
        dir <= d;
        run <= 1'b1;
        repeat (n * 100) @(posedge core_clk);
        run <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_sim;
    end
    initial begin
        logic [6:0] inv;
        void'($urandom(32'h5162));
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        apb(0, 12'h004, 0, 32'h0000_0400);
        apb(0, 12'h010, 0, 32'h0000_0000);
        apb(0, 12'h020, 0, 32'h0000_0000);
        apb(1, 12'h004, 32'h0000_2711, 0);
        apb(0, 12'h004, 0, 32'h0000_2710);
        apb(1, 12'h004, 32'h0000_0000, 0);
        apb(0, 12'h004, 0, 32'h0000_0001);
        for (int m = 0; m < 3; m++) begin
            apb(1, 12'h000, m, 0);
            apb(0, 12'h000, 0, m);
        end
        $display("test registers done");
        repeat (4) begin
            inv = 7'($urandom);
            raw <= 5'($urandom);
            apb(1, 12'h000, 32'({inv, 8'h00}), 0);
            apb(0, 12'h00C, 0, 32'({b, a, raw} ^ inv));
        end
        $display("test inputs done");
        // Only modes 0 and 2 are used for counting.
        apb(1, 12'h000, 32'h0000_0004, 0);
        apb(0, 12'h010, 0, 32'h0000_0000);
        apb(1, 12'h000, 32'h0000_0000, 0);
        spin(8, 0);
        apb(0, 12'h010, 0, 32'h0000_0008);
        fork
            spin(12, 1);
            begin
                repeat (600) @(posedge core_clk);
                apb(0, 12'h014, 0, 32'hFFFF_FF38);
                apb(0, 12'h018, 0, 32'hFFFF_FB50);
                apb(0, 12'h01C, 0, 32'hFFFF_E0C0);
            end
        join
        apb(0, 12'h010, 0, 32'hFFFF_FFFC);
        apb(1, 12'h000, 32'h0000_6000, 0);
        apb(0, 12'h010, 0, 32'hFFFF_FFFC);
        apb(1, 12'h000, 32'h0000_0008, 0);
        spin(4, 0);
        apb(0, 12'h010, 0, 32'hFFFF_FFF8);
        $display("test quadrature done");
        pulse <= 1'b1;
        apb(1, 12'h000, 32'h0000_0006, 0);
        apb(1, 12'h000, 32'h0000_0002, 0);
        spin(8, 0);
        apb(0, 12'h010, 0, 32'h0000_0002);
        $display("test pulse done");
        end_sim;
    end
endmodule

// File: design/encoder_defines.vh
// Constants for the shaft-encoder speed and position input block.
// Notes on behaviour
// [RULE1] Mode 0 decodes a two-phase pair on inputs 6 and 7, mode 1 pulse plus direction on 6 and 7, mode 2 pulses on input 7 only.
// [RULE2] Software should only pick two-phase or single-pulse mode; pulse plus direction is not supported.
// [RULE3] While position clear is high the position count is forced to zero and held there.
// [RULE4] Direction invert negates every speed output and reverses the position count direction.
// [RULE5] Once position clear is released, encoder events count up for one direction and down for the other.
// [RULE6] Position is a signed 16-bit count that wraps between 32767 and -32768 without saturating.
// [RULE7] Encoder resolution is held in pulses per revolution from 1 to 10000 and used to scale speed.
// [RULE8] Speed is reported in hertz, in revolutions per minute and as a percentage of top speed.
// [RULE9] The encoder must not exceed 100kHz on either line, the rate being top rpm times lines over 60.
// [RULE10] Each digital input passes its level to its output, inverted when its invert bit is set.
// [RULE11] There are seven independent digital inputs, each with its own invert bit and output.
// [RULE12] In two-phase mode the leading phase sets direction, each valid transition counts one, a double change is ignored.
// [RULE13] In single-pulse mode each rising edge on input 7 counts up, subject to invert, and input 6 stays a plain input.
`ifndef ENCODER_DEFINES_VH
`define ENCODER_DEFINES_VH
`define ADDR_CONTROL     12'h000
`define ADDR_LINES       12'h004
`define ADDR_TOP_RPM     12'h008
`define ADDR_INPUTS      12'h00C
`define ADDR_POSITION    12'h010
`define ADDR_SPEED_HERTZ    12'h014
`define ADDR_SPEED_REV_PER_MIN   12'h018
`define ADDR_SPEED_PCT   12'h01C
`define MODE_QUAD        2'h0
`define MODE_CLKDIR      2'h1
`define MODE_CLOCK       2'h2
`define CTL_MODE_LSB     0
`define CTL_CLEAR_BIT    2
`define CTL_INVERT_BIT   3
`define CTL_DIN_INV_LSB  8
`define LINES_MIN        14'h0001
`define LINES_MAX        14'h2710
`define LINES_RESET      14'h0400
`define TOP_RPM_RESET    16'h05DC
`define CLK_HZ           40000000
`define GATE_MS          100
`define GATE_PER_SEC     10
`define SEC_PER_MIN      60
`define PCT_SCALE        10000
`endif

// File: design/encoder_speed_position_input.v
// Shaft-encoder decoder with position count, speed scaling and APB access.
`include "encoder_defines.vh"
module encoder_speed_position_input #(
    parameter integer NUM_INPUTS  = 7,
    parameter integer GATE_CYCLES = `CLK_HZ / 1000 * `GATE_MS
) (
    input  wire        core_clk,          // System clock, 40 MHz
    input  wire        reset_n,           // Synchronous reset, active low
    input  wire [NUM_INPUTS-1:0] din_raw, // Conditioned terminal levels
    output reg  [NUM_INPUTS-1:0] din_value, // Inputs after inversion
    output reg  [15:0] position,          // Signed wrapping position
    output reg  [31:0] speed_hertz,       // Signed, tenths of a hertz
    output reg  [31:0] speed_rev_per_min, // Signed, rev per minute
    output reg  [31:0] speed_percent,     // Signed, hundredths of a %
    input  wire        psel,              // APB select
    input  wire        penable,           // APB enable
    input  wire        pwrite,            // APB write
    input  wire [11:0] paddr,             // APB byte address
    input  wire [31:0] pwdata,            // APB write data
    output reg  [31:0] prdata,            // APB read data
    output wire        pready,            // APB ready
    output wire        pslverr            // APB error
);
    // Overview of the data path.
    //
    // All seven terminal levels pass through one register stage, where each
    // is inverted by its own control bit. Inputs 6 and 7 are then picked off
    // the conditioned bus as the counting lines. Decoding works on the
    // conditioned levels, never on the raw pins. Inverting one line therefore
    // also swaps the count direction in two-phase mode, just as swapping the
    // wires would.
    //
    // The decoder turns each pair of consecutive samples into a step of -1,
    // 0 or +1. The speed accumulator adds that step, and the position counter
    // adds the same step except while position clear holds it at zero.
    //
    // Speed is measured by gating. Steps are summed for a fixed number of
    // clock cycles and the three scaled results are reloaded once per gate.
    // A long gate gives fine resolution at low speed but a slow response;
    // the gate length is a parameter so that the trade can be chosen.
    //
    // Limitation: the scaling constants assume the default gate length of
    // one tenth of a second. A shorter gate gives proportionally smaller
    // readings and is meant only for quick checks.
    //
    reg  [1:0]  mode;
    reg         pos_clear;
    reg         dir_invert;
    reg  [NUM_INPUTS-1:0] din_invert;
    reg  [13:0] lines;
    reg  [15:0] top_rpm;
    reg  [1:0]  prev_ab;
    reg  [31:0] gate_cnt;
    reg  signed [31:0] pulse_acc;
    reg  signed [1:0]  step;
    wire        chan_a = din_value[5];
    wire        chan_b = din_value[6];
    wire        apb_wr = psel & penable & pwrite;
    wire        gate_end = (gate_cnt == GATE_CYCLES - 1);
    reg         addr_ok;

    // Input conditioning, one stage per channel.
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g = g + 1) begin : g_din
            always @(posedge core_clk) begin
                if (!reset_n)
                    din_value[g] <= 1'b0;
                else
                    din_value[g] <= din_raw[g] ^ din_invert[g]; // [RULE10] [RULE11]
            end
        end
    endgenerate

    // Count step from the decoded inputs; mode 1 is decoded even though
    // software is told not to use it.
    // The previous sample of both lines is kept in prev_ab, A in the upper
    // bit. A change of both lines in one sample cannot be given a direction,
    // so it is dropped rather than guessed; at the rated line frequency the
    // lines are sampled many times between edges, so this only happens on
    // noise or a wiring fault.
    // In the single-line modes only rising edges of input 7 count, which
    // cuts the resolution to a quarter of two-phase decoding.
    always @* begin
        step = 2'sd0;
        case (mode) // [RULE1]
            `MODE_QUAD: begin
                // Gray sequence 00,01,11,10 counts up; double change ignored.
                case ({prev_ab, chan_a, chan_b}) // [RULE12]
                    4'b0001, 4'b0111, 4'b1110, 4'b1000: step = 2'sd1;
                    4'b0010, 4'b1011, 4'b1101, 4'b0100: step = -2'sd1;
                    default: step = 2'sd0;
                endcase
            end
            `MODE_CLKDIR: begin
                if (chan_b & ~prev_ab[0])
                    step = chan_a ? -2'sd1 : 2'sd1;
            end
            `MODE_CLOCK: begin
                if (chan_b & ~prev_ab[0])
                    step = 2'sd1; // [RULE13]
            end
            default: step = 2'sd0;
        endcase
        if (dir_invert)
            step = -step; // [RULE4]
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            prev_ab  <= 2'b00;
            position <= 16'h0000;
        end else begin
            prev_ab <= {chan_a, chan_b};
            if (pos_clear)
                position <= 16'h0000; // [RULE3]
            else
                position <= position + {{14{step[1]}}, step}; // [RULE5] [RULE6]
        end
    end

    // Pulses are summed over a fixed gate; speed refreshes once per gate.
    // Frequency here is counts per second over lines, so resolution is one count per
    // gate divided by the line count.
    always @(posedge core_clk) begin
        if (!reset_n) begin
            gate_cnt          <= 32'h0000_0000;
            pulse_acc         <= 32'sh0000_0000;
            speed_hertz       <= 32'h0000_0000;
            speed_rev_per_min <= 32'h0000_0000;
            speed_percent     <= 32'h0000_0000;
        end else if (gate_end) begin
            gate_cnt  <= 32'h0000_0000;
            // The step of the closing cycle opens the next gate, so no
            // count is lost when an edge falls on the gate boundary.
            pulse_acc <= {{30{step[1]}}, step};
            // Hz to one decimal: counts/gate * gates/s * 10 / lines.
            speed_hertz <= (pulse_acc * `GATE_PER_SEC * 10)
                           / $signed({18'h0_0000, lines}); // [RULE7] [RULE8]
            speed_rev_per_min <= (pulse_acc * `GATE_PER_SEC * `SEC_PER_MIN)
                                 / $signed({18'h0_0000, lines}); // [RULE8]
            speed_percent <= (pulse_acc * `GATE_PER_SEC * `SEC_PER_MIN
                              * `PCT_SCALE)
                             / ($signed({18'h0_0000, lines})
                                * $signed({16'h0000, top_rpm})); // [RULE8]
        end else begin
            gate_cnt  <= gate_cnt + 32'h0000_0001;
            pulse_acc <= pulse_acc + {{30{step[1]}}, step};
        end
    end

    // APB slave: zero wait state; unmapped addresses answer with an error.
    // Read data is decoded straight from the address so that the access
    // phase can finish at once. The values read are themselves registers,
    // so the read path is one decoder deep.
    // Writes to read-only or unmapped offsets change nothing.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always @* begin
        addr_ok = 1'b1;
        prdata  = 32'h0000_0000;
        case (paddr)
            `ADDR_CONTROL:   prdata = {16'h0000, {(8-NUM_INPUTS){1'b0}},
                                       din_invert, 4'h0, dir_invert,
                                       pos_clear, mode};
            `ADDR_LINES:     prdata = {18'h0_0000, lines};
            `ADDR_TOP_RPM:   prdata = {16'h0000, top_rpm};
            `ADDR_INPUTS:    prdata = {{(32-NUM_INPUTS){1'b0}}, din_value};
            `ADDR_POSITION:  prdata = {{16{position[15]}}, position};
            `ADDR_SPEED_HERTZ:  prdata = speed_hertz;
            `ADDR_SPEED_REV_PER_MIN: prdata = speed_rev_per_min;
            `ADDR_SPEED_PCT: prdata = speed_percent;
            default:         addr_ok = 1'b0;
        endcase
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            mode       <= `MODE_QUAD;
            pos_clear  <= 1'b0;
            dir_invert <= 1'b0;
            din_invert <= {NUM_INPUTS{1'b0}};
            lines      <= `LINES_RESET;
            top_rpm    <= `TOP_RPM_RESET;
        end else if (apb_wr) begin
            // Configuration writes land at the end of the access phase.
            // A new mode takes effect on the next sample of the lines,
            // so changing mode while the shaft turns may miss one count.
            case (paddr)
                `ADDR_CONTROL: begin
                    mode       <= pwdata[`CTL_MODE_LSB +: 2];
                    pos_clear  <= pwdata[`CTL_CLEAR_BIT];
                    dir_invert <= pwdata[`CTL_INVERT_BIT];
                    din_invert <= pwdata[`CTL_DIN_INV_LSB +: NUM_INPUTS];
                end
                `ADDR_LINES: begin
                    // Out-of-range values are clamped so division stays safe.
                    if (pwdata[13:0] < `LINES_MIN || pwdata[31:14] != 0)
                        lines <= (pwdata[31:14] != 0) ? `LINES_MAX
                                                      : `LINES_MIN; // [RULE7]
                    else if (pwdata[13:0] > `LINES_MAX)
                        lines <= `LINES_MAX;
                    else
                        lines <= pwdata[13:0];
                end
                `ADDR_TOP_RPM: begin
                    if (pwdata[15:0] != 16'h0000)
                        top_rpm <= pwdata[15:0];
                end
                default: ;
            endcase
        end
    end
endmodule
